// ===== rtl/rkic_top.sv
// Overview of operation
// - Calibration enable drives pulse onto pin
// - Two-bit field picks calibration frequency
// - Pin function fields decode both interrupt pins
// - Power write needs key A7 first
// - Time and pin writes need key EA
// - Time counters advance on crystal edges
// - Setup and alarm writes land on tick
// - Counters keep running while being read
// - Hours wrap at 23 or 255
// - Day wrap sets flag and pending request
// - Day wrap wakes core from deep sleep
// - One enable gates both interrupt sources
// - Vectoring clears the pending request
// - Disabled interrupt keeps request pending
// - Flags stay set until software clears
// - Wake repeats until request is serviced
// - Fractional counter wraps 127, bumps seconds
// - Seconds and minutes wrap at 59
// - Counters cleared only by power-on reset
// - Interval match sets alarm and request
//
// Holds the RTC key protection, counters, flags, wake and pin config.
// Assumes the core drives the register strobes on clk; crystal is async.
`timescale 1ns/10ps
module rkic_top import rkic_pkg::*; (
	// Clock, power-on reset and warm reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic warmRst,
	// Crystal clock pin
	input wire logic xtalClk,
	// Register port from the core
	input wire logic [7:0] sfrAddr,
	input wire logic sfrWrEn,
	input wire logic [7:0] sfrWrData,
	input wire logic sfrRdEn,
	output logic [7:0] sfrRdData,
	// Interrupt and sleep handshake
	input wire logic rtcIrqEnable,
	input wire logic irqVectorAck,
	input wire logic deepSleep,
	output logic rtcIrqReq,
	output logic wakeReq,
	// Power control write port
	output logic powerCtrlWrStb,
	output logic [7:0] powerCtrlWrData,
	// Calibration pin
	output logic calPinOut,
	output logic calPinOe,
	// Interrupt pin functions
	output logic irqPinBGpio,
	output logic batteryControlInput,
	output logic irqPinBEnable,
	output logic irqPinAEnable
);

	logic [7:0] keyReg;
	logic [7:0] keyNext;
	logic [7:0] pinCfgReg;
	logic [7:0] setupReg;
	logic [7:0] setupShadowReg;
	logic setupPendReg;
	logic [7:0] alarmTargetReg;
	logic [7:0] alarmShadowReg;
	logic alarmPendReg;
	logic [7:0] intervalCntReg;
	logic irqPendReg;
	logic irqPendNext;
	logic xtalS1Reg;
	logic xtalS2Reg;
	logic xtalS3Reg;
	logic [PRESC_W-1:0] prescReg;
	logic [1:0] tickWaitReg;

	// Crystal synchroniser; the first stage feeds only the second
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			xtalS1Reg <= 1'b0;
			xtalS2Reg <= 1'b0;
			xtalS3Reg <= 1'b0;
		end else begin
			xtalS1Reg <= xtalClk;
			xtalS2Reg <= xtalS1Reg;
			xtalS3Reg <= xtalS2Reg;
		end
	end

	// Crystal edge, 128 Hz tick and calibration tap
	wire xtalEdge = xtalS2Reg && !xtalS3Reg;
	wire fracTick = xtalEdge && (prescReg[7:0] == PRESC_TICK);
	wire [1:0] cal_freq_choice = pinCfgReg[PIN_CAL_FREQ_CHOICE_HI:PIN_CAL_FREQ_CHOICE_LO];
	wire calTap = (cal_freq_choice == CAL_FREQ_CHOICE_1HZ) ? prescReg[CAL_BIT_1HZ] :
		(cal_freq_choice == CAL_FREQ_CHOICE_16KHZ) ? prescReg[CAL_BIT_16KHZ] : prescReg[CAL_BIT_512HZ];

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prescReg <= '0;
		end else if (xtalEdge) begin
			prescReg <= prescReg + 1'b1;
		end
	end

	// Register decode
	wire timeUnlocked = (keyReg == KEY_TIME);
	wire powerUnlocked = (keyReg == KEY_POWER);
	wire wrKey = sfrWrEn && (sfrAddr == OFF_KEY);
	wire wrSetup = sfrWrEn && (sfrAddr == OFF_SETUP);
	wire wrAlarm = sfrWrEn && (sfrAddr == OFF_ALARM);
	wire tryPin = sfrWrEn && (sfrAddr == OFF_PINCFG);
	wire tryTally = sfrWrEn && (sfrAddr >= OFF_FRAC) && (sfrAddr <= OFF_HOUR);
	wire tryPower = sfrWrEn && (sfrAddr == OFF_POWER);
	wire wrPin = tryPin && timeUnlocked;
	wire wrTally = tryTally && timeUnlocked;
	wire wrPower = tryPower && powerUnlocked;
	wire protAccepted = wrPin || wrTally || wrPower;
	wire [1:0] tallySel = 2'(sfrAddr - OFF_FRAC);

	assign keyNext = wrKey ? sfrWrData : (protAccepted ? KEY_RESET : keyReg);

	// Key register; warm reset relocks
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			keyReg <= KEY_RESET;
		end else if (warmRst) begin
			keyReg <= KEY_RESET;
		end else begin
			keyReg <= keyNext;
		end
	end

	// pin config changes only on keyed write, warm reset or power-on reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pinCfgReg <= PIN_RESET;
		end else if (warmRst) begin
			pinCfgReg <= PIN_RESET;
		end else if (wrPin) begin
			pinCfgReg <= sfrWrData & PIN_MASK;
		end
	end

	// Time counters: fractional, seconds, minutes, hours
	rkic_tally_if #(.W(8)) tIf[4] ();
	wire dayLen = setupReg[SETUP_DAY_LEN];

	genvar gi;
	for (gi = 0; gi < 4; gi++) begin : gTally
		if (gi == 0) begin : gHead
			assign tIf[gi].inc = fracTick;
			assign tIf[gi].wrapAt = WRAP_FRAC;
		end else begin : gBody
			assign tIf[gi].inc = tIf[gi-1].carry;
			assign tIf[gi].wrapAt = (gi < 3) ? WRAP_SIXTY :
				(dayLen ? WRAP_HOUR24 : WRAP_HOUR256);
		end
		assign tIf[gi].load = wrTally && (tallySel == 2'(gi));
		assign tIf[gi].loadVal = sfrWrData;
		rkic_tally #(.W(8)) uTally (
			.clk(clk),
			.nrst(nrst),
			.port(tIf[gi])
		);
	end

	// Events
	wire dayWrap = tIf[3].carry;
	wire secTick = tIf[0].carry;
	wire [7:0] intervalNext = intervalCntReg + 8'h01;
	wire alarmEvent = secTick && setupReg[SETUP_IVL_EN] && (intervalNext == alarmTargetReg);
	wire applySetup = fracTick && setupPendReg;
	wire applyAlarm = fracTick && alarmPendReg;

	// shadows wait for the 128 Hz tick
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			setupShadowReg <= SETUP_RESET;
			setupPendReg <= 1'b0;
			alarmShadowReg <= 8'h00;
			alarmPendReg <= 1'b0;
		end else begin
			if (wrSetup) begin
				setupShadowReg <= sfrWrData;
			end
			setupPendReg <= wrSetup || (setupPendReg && !fracTick);
			if (wrAlarm) begin
				alarmShadowReg <= sfrWrData;
			end
			alarmPendReg <= wrAlarm || (alarmPendReg && !fracTick);
		end
	end

	// Setup register bits as applied on the tick
	wire [7:0] setupApplied = applySetup ? (setupShadowReg & SETUP_MASK) : setupReg;
	// writing zero clears a flag, events win
	wire alarmFlagNext = (applySetup ? setupShadowReg[SETUP_ALARM_FLAG] &&
		setupReg[SETUP_ALARM_FLAG] : setupReg[SETUP_ALARM_FLAG]) || alarmEvent;
	wire dayFlagNext = (applySetup ? setupShadowReg[SETUP_DAYWRAP_FLAG] &&
		setupReg[SETUP_DAYWRAP_FLAG] : setupReg[SETUP_DAYWRAP_FLAG]) || dayWrap;

	// Active setup, alarm target and interval count
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			setupReg <= SETUP_RESET;
			alarmTargetReg <= 8'h00;
			intervalCntReg <= 8'h00;
		end else begin
			setupReg <= {setupApplied[7:4], dayFlagNext, alarmFlagNext, setupApplied[1:0]};
			if (applyAlarm) begin
				alarmTargetReg <= alarmShadowReg;
			end
			if (!setupReg[SETUP_IVL_EN] || alarmEvent) begin
				intervalCntReg <= 8'h00;
			end else if (secTick) begin
				intervalCntReg <= intervalNext;
			end
		end
	end

	assign irqPendNext = (irqPendReg && !(irqVectorAck && rtcIrqEnable)) ||
		dayWrap || alarmEvent;

	// Pending request, requests, wake and power write
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irqPendReg <= 1'b0;
			rtcIrqReq <= 1'b0;
			wakeReq <= 1'b0;
			powerCtrlWrStb <= 1'b0;
			powerCtrlWrData <= 8'h00;
		end else begin
			irqPendReg <= irqPendNext;
			rtcIrqReq <= irqPendNext && rtcIrqEnable;
			wakeReq <= irqPendNext && deepSleep;
			powerCtrlWrStb <= wrPower;
			if (wrPower) begin
				powerCtrlWrData <= sfrWrData;
			end
		end
	end

	wire pinBGpioNext = pinCfgReg[2:1] == 2'b00;
	wire pinBBattNext = pinCfgReg[2:1] == 2'b01;
	wire pinBEnNext = pinCfgReg[PIN_B_HI:PIN_B_LO+1] == 2'b11;

	// Pin and calibration outputs
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			calPinOut <= 1'b0;
			calPinOe <= 1'b0;
			irqPinBGpio <= 1'b1;
			batteryControlInput <= 1'b0;
			irqPinBEnable <= 1'b0;
			irqPinAEnable <= 1'b0;
		end else begin
			// drive pulse when enabled, tap choice
			calPinOut <= pinCfgReg[PIN_CAL_EN] && calTap;
			calPinOe <= pinCfgReg[PIN_CAL_EN];
			irqPinBGpio <= pinBGpioNext;
			batteryControlInput <= pinBBattNext;
			irqPinBEnable <= pinBEnNext;
			irqPinAEnable <= pinCfgReg[PIN_A_EN];
		end
	end

	// live counter values returned while counting
	wire [7:0] rdMux =
		(sfrAddr == OFF_SETUP) ? setupReg :
		(sfrAddr == OFF_FRAC) ? tIf[0].value :
		(sfrAddr == OFF_SEC) ? tIf[1].value :
		(sfrAddr == OFF_MIN) ? tIf[2].value :
		(sfrAddr == OFF_HOUR) ? tIf[3].value :
		(sfrAddr == OFF_ALARM) ? alarmTargetReg :
		(sfrAddr == OFF_KEY) ? keyReg :
		(sfrAddr == OFF_PINCFG) ? pinCfgReg : 8'h00;

	// Read data register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sfrRdData <= 8'h00;
		end else if (sfrRdEn) begin
			sfrRdData <= rdMux;
		end
	end

	// Ticks seen while a setup write waits
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tickWaitReg <= 2'b00;
		end else if (!setupPendReg || wrSetup) begin
			tickWaitReg <= 2'b00;
		end else if (fracTick && tickWaitReg != 2'b11) begin
			tickWaitReg <= tickWaitReg + 2'b01;
		end
	end

	a_setup_tick_bound: assert property (@(posedge clk) disable iff (!nrst)
		setupPendReg |-> tickWaitReg == 2'b00)
		else $error("setup write waited past its tick");

	a_power_key_gate: assert property (@(posedge clk) disable iff (!nrst)
		powerCtrlWrStb |-> $past(keyReg) == KEY_POWER)
		else $error("power write without its key");

	a_pin_unkeyed: assert property (@(posedge clk) disable iff (!nrst || warmRst)
		tryPin && keyReg != KEY_TIME |=> $stable(pinCfgReg))
		else $error("unkeyed pin config write took effect");

	a_key_consumed: assert property (@(posedge clk) disable iff (!nrst)
		tryTally && keyReg == KEY_TIME |=> keyReg == KEY_RESET)
		else $error("key not consumed by protected write");

	a_day_flag_irq: assert property (@(posedge clk) disable iff (!nrst)
		dayWrap |=> setupReg[SETUP_DAYWRAP_FLAG] && irqPendReg)
		else $error("day wrap lost flag or request");

	a_hour_24_wrap: assert property (@(posedge clk) disable iff (!nrst)
		dayWrap && dayLen |-> tIf[3].value == WRAP_HOUR24)
		else $error("24-hour wrap at wrong hour");

	a_irq_held: assert property (@(posedge clk) disable iff (!nrst)
		irqPendReg && !rtcIrqEnable |=> irqPendReg ##1 !rtcIrqReq || rtcIrqEnable)
		else $error("pending request dropped while disabled");

	a_irq_vector_clear: assert property (@(posedge clk) disable iff (!nrst)
		irqPendReg && rtcIrqEnable && irqVectorAck && !dayWrap && !alarmEvent
		|=> !irqPendReg)
		else $error("vectoring did not clear request");

	a_wake_repeat: assert property (@(posedge clk) disable iff (!nrst)
		irqPendReg && deepSleep && !irqVectorAck |=> wakeReq)
		else $error("no wake while request pending");

	a_cal_drive: assert property (@(posedge clk) disable iff (!nrst || warmRst)
		pinCfgReg[PIN_CAL_EN] |=> calPinOe)
		else $error("calibration pin not driven");

	a_alarm_flag: assert property (@(posedge clk) disable iff (!nrst)
		alarmEvent |=> setupReg[SETUP_ALARM_FLAG] && irqPendReg)
		else $error("alarm match lost flag or request");

endmodule

// ===== rtl/rkic_pkg.sv
// Constants for the RTC key, interrupt and pin-configuration block.
// Assumes an 8-bit special function register bus from the on-chip core.
package rkic_pkg;

	// Register addresses
	localparam logic [7:0] OFF_SETUP = 8'hA1;
	localparam logic [7:0] OFF_FRAC = 8'hA2;
	localparam logic [7:0] OFF_SEC = 8'hA3;
	localparam logic [7:0] OFF_MIN = 8'hA4;
	localparam logic [7:0] OFF_HOUR = 8'hA5;
	localparam logic [7:0] OFF_ALARM = 8'hA6;
	localparam logic [7:0] OFF_KEY = 8'hC1;
	localparam logic [7:0] OFF_POWER = 8'hC5;
	localparam logic [7:0] OFF_PINCFG = 8'hFF;

	// Unlock key values
	localparam logic [7:0] KEY_POWER = 8'hA7;
	localparam logic [7:0] KEY_TIME = 8'hEA;
	localparam logic [7:0] KEY_RESET = 8'h00;

	// rtc_setup fields
	localparam int SETUP_IVL_EN = 0;
	localparam int SETUP_DAY_LEN = 1;
	localparam int SETUP_ALARM_FLAG = 2;
	localparam int SETUP_DAYWRAP_FLAG = 3;
	localparam logic [7:0] SETUP_RESET = 8'h00;
	localparam logic [7:0] SETUP_MASK = 8'h0F;

	// pin_and_cal_config fields
	localparam int PIN_CAL_EN = 7;
	localparam int PIN_CAL_FREQ_CHOICE_HI = 6;
	localparam int PIN_CAL_FREQ_CHOICE_LO = 5;
	localparam int PIN_B_HI = 3;
	localparam int PIN_B_LO = 1;
	localparam int PIN_A_EN = 0;
	localparam logic [7:0] PIN_RESET = 8'h00;
	localparam logic [7:0] PIN_MASK = 8'hEF;

	// Counter wrap values
	localparam logic [7:0] WRAP_FRAC = 8'h7F;
	localparam logic [7:0] WRAP_SIXTY = 8'h3B;
	localparam logic [7:0] WRAP_HOUR24 = 8'h17;
	localparam logic [7:0] WRAP_HOUR256 = 8'hFF;
	localparam logic [7:0] TALLY_RESET = 8'h00;

	// Crystal prescaler: 256 crystal edges per 1/128 s tick
	localparam int PRESC_W = 15;
	localparam logic [7:0] PRESC_TICK = 8'hFF;
	localparam int CAL_BIT_1HZ = 14;
	localparam int CAL_BIT_512HZ = 5;
	localparam int CAL_BIT_16KHZ = 0;

	// Calibration frequency choices
	typedef enum logic [1:0] {
		CAL_FREQ_CHOICE_1HZ,
		CAL_FREQ_CHOICE_512HZ,
		CAL_FREQ_CHOICE_500HZ,
		CAL_FREQ_CHOICE_16KHZ
	} rkic_cal_freq_choice_e;

endpackage

// ===== rtl/rkic_tally_if.sv
// Carrier between the main block and one wrapping time counter.
// Assumes the user side drives increment, load and wrap value.
`timescale 1ns/10ps
interface rkic_tally_if #(parameter int W = 8);
	logic inc;
	logic load;
	logic [W-1:0] loadVal;
	logic [W-1:0] wrapAt;
	logic [W-1:0] value;
	logic carry;

	modport tally (input inc, input load, input loadVal, input wrapAt,
		output value, output carry);
	modport user (output inc, output load, output loadVal, output wrapAt,
		input value, input carry);
endinterface

// ===== rtl/rkic_tally.sv
// One wrapping time counter with a load port that beats the increment.
// Assumes inc is a single-cycle enable from the crystal tick logic.
`timescale 1ns/10ps
module rkic_tally import rkic_pkg::*; #(parameter int W = 8) (
	// Clock and power-on reset
	input wire logic clk,
	input wire logic nrst,
	// Counter carrier
	rkic_tally_if.tally port
);
	logic [W-1:0] valueReg;
	logic [W-1:0] valueNext;
	logic atWrap;

	// Wrap detect and next value
	assign atWrap = (valueReg == port.wrapAt);
	assign port.carry = port.inc && atWrap && !port.load;
	assign port.value = valueReg;
	assign valueNext = port.load ? port.loadVal :
		(port.inc ? (atWrap ? '0 : valueReg + 1'b1) : valueReg);

	// Only power-on reset clears the count
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			valueReg <= '0;
		end else begin
			valueReg <= valueNext;
		end
	end

	a_wrap_to_zero: assert property (@(posedge clk) disable iff (!nrst)
		port.carry |=> valueReg == '0)
		else $error("counter did not wrap to zero");

	a_idle_hold: assert property (@(posedge clk) disable iff (!nrst)
		!port.inc && !port.load |=> $stable(valueReg))
		else $error("counter moved without a tick or load");

endmodule

// ===== sim/rkic_core_model.sv
// Core-side model: takes the RTC vector after a chosen delay.
// Assumes rtcIrqReq is the registered request of the RTC block.
`timescale 1ns/10ps
module rkic_core_model (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Vectoring handshake
	input wire logic rtcIrqReq,
	input wire logic [7:0] ackDelay,
	output logic irqVectorAck
);
	logic [7:0] waitCnt;

	// vector on request
	// One acknowledge pulse per request; the delay makes the core prompt or slow
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			waitCnt <= 8'h00;
			irqVectorAck <= 1'b0;
		end else begin
			irqVectorAck <= 1'b0;
			if (rtcIrqReq && !irqVectorAck) begin
				if (waitCnt == ackDelay) begin
					irqVectorAck <= 1'b1;
					waitCnt <= 8'h00;
				end else begin
					waitCnt <= waitCnt + 8'h01;
				end
			end else begin
				waitCnt <= 8'h00;
			end
		end
	end
endmodule

// ===== sim/rtc_key_irq_control_bench.sv
// Self-checking bench for the RTC key, interrupt and pin block.
// Assumes the core model answers vectoring; crystal runs at ~8 clk per period.
`timescale 1ns/10ps
module rtc_key_irq_control_bench import rkic_pkg::*; ;
	logic clk = 0, nrst = 0, warmRst = 0, xtalClk = 0, sfrWrEn = 0, sfrRdEn = 0;
	logic rtcIrqEnable = 0, deepSleep = 0, prevCal;
	logic [7:0] sfrAddr = 0, sfrWrData = 0, ackDelay = 0, v, p, s;
	logic [7:0] sfrRdData, powerCtrlWrData;
	logic irqVectorAck, rtcIrqReq, wakeReq, powerCtrlWrStb, calPinOut, calPinOe;
	logic gpio, batt, bEn, aEn;
	int n_errors = 0, checks_done = 0, nStb = 0, i, n;

	// Clocks and strobe counter
	always #2.5 clk = ~clk;
	always #20.3 xtalClk = ~xtalClk;
	always @(negedge clk) if (powerCtrlWrStb === 1'b1) nStb++;

	rkic_top u_dut (.clk(clk), .nrst(nrst), .warmRst(warmRst), .xtalClk(xtalClk),
		.sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn),
		.sfrRdData(sfrRdData), .rtcIrqEnable(rtcIrqEnable), .irqVectorAck(irqVectorAck),
		.deepSleep(deepSleep), .rtcIrqReq(rtcIrqReq), .wakeReq(wakeReq),
		.powerCtrlWrStb(powerCtrlWrStb), .powerCtrlWrData(powerCtrlWrData),
		.calPinOut(calPinOut), .calPinOe(calPinOe), .irqPinBGpio(gpio),
		.batteryControlInput(batt), .irqPinBEnable(bEn), .irqPinAEnable(aEn));
	rkic_core_model u_core (.clk(clk), .nrst(nrst), .rtcIrqReq(rtcIrqReq),
		.ackDelay(ackDelay), .irqVectorAck(irqVectorAck));

	// Compare and count
	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task finish_test;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task hang(input int k);
		if (k >= 5000) begin
			chk("wait", 8'h00, 8'h01);
			finish_test();
		end
	endtask
	// Register bus cycles
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfrAddr = a;
		sfrWrData = d;
		sfrWrEn = 1;
		@(negedge clk);
		sfrWrEn = 0;
	endtask
	task kwr(input logic [7:0] k, input logic [7:0] a, input logic [7:0] d);
		wr(OFF_KEY, k);
		wr(a, d);
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		sfrAddr = a;
		sfrRdEn = 1;
		@(negedge clk);
		sfrRdEn = 0;
		@(negedge clk);
		d = sfrRdData;
	endtask
	// Expected pin decodes: gpio, battery, pin B enable, pin A enable
	function logic [7:0] pinExp(input logic [7:0] c);
		return {4'h0, c[2:1] == 2'b00, c[2:1] == 2'b01, c[3:2] == 2'b11, c[0]};
	endfunction
	// Rising edges of the cal pin in 126 crystal periods
	function logic [7:0] calOk(input int f, input int k);
		case (f)
			0: return 8'(k <= 1);
			3: return 8'(k >= 55 && k <= 70);
			default: return 8'(k >= 1 && k <= 3);
		endcase
	endfunction

	initial begin
		void'($urandom(32'hB0D0));
		repeat (8) @(negedge clk);
		nrst = 1;
		for (i = 0; i < 6; i++) begin
			rd(8'(OFF_SETUP + i), v);
			chk("reg reset", v, 8'h00);
		end
		chk("pins reset", {4'h0, gpio, batt, bEn, aEn}, 8'h08);
		// Key protection of the time counters
		s = 8'($urandom_range(59, 1));
		wr(OFF_SEC, s);
		rd(OFF_SEC, v);
		chk("sec nokey", v, 8'h00);
		kwr(KEY_POWER, OFF_SEC, s);
		rd(OFF_SEC, v);
		chk("sec wrong key", v, 8'h00);
		kwr(KEY_TIME, OFF_SEC, s);
		rd(OFF_SEC, v);
		chk("sec keyed", v, s);
		wr(OFF_SEC, 8'h00);
		rd(OFF_SEC, v);
		chk("sec rekey", v, s);
		rd(OFF_KEY, v);
		chk("key spent", v, KEY_RESET);
		// Power control key
		kwr(KEY_TIME, OFF_POWER, 8'h5A);
		chk("pwr wrong key", 8'(nStb), 8'h00);
		p = 8'($urandom);
		kwr(KEY_POWER, OFF_POWER, p);
		@(negedge clk);
		chk("pwr stb", 8'(nStb), 8'h01);
		chk("pwr data", powerCtrlWrData, p);
		// Every pin B function code, random other bits
		for (i = 0; i < 8; i++) begin
			p = 8'($urandom);
			p[3:1] = i[2:0];
			kwr(KEY_TIME, OFF_PINCFG, p);
			repeat (2) @(negedge clk);
			chk("pins", {4'h0, gpio, batt, bEn, aEn}, pinExp(p));
			chk("cal oe", {7'h0, calPinOe}, {7'h0, p[7]});
			rd(OFF_PINCFG, v);
			chk("pincfg", v, p & PIN_MASK);
		end
		// Every cal frequency choice
		for (i = 0; i < 4; i++) begin
			kwr(KEY_TIME, OFF_PINCFG, {1'b1, i[1:0], 5'h00});
			prevCal = calPinOut;
			n = 0;
			repeat (1024) begin
				@(negedge clk);
				if (calPinOut === 1'b1 && prevCal === 1'b0) n++;
				prevCal = calPinOut;
			end
			chk("cal rate", calOk(i, n), 8'h01);
		end
		kwr(KEY_TIME, OFF_PINCFG, 8'h00);
		repeat (2) @(negedge clk);
		chk("cal off", {6'h0, calPinOe, calPinOut}, 8'h00);
		// Warm reset keeps counters, drops key and pin config
		kwr(KEY_TIME, OFF_PINCFG, 8'h0F);
		wr(OFF_KEY, KEY_TIME);
		@(negedge clk) warmRst = 1;
		@(negedge clk) warmRst = 0;
		rd(OFF_SEC, v);
		chk("sec warm", v, s);
		rd(OFF_KEY, v);
		chk("key warm", v, 8'h00);
		chk("pins warm", {4'h0, gpio, batt, bEn, aEn}, 8'h08);
		// Day wrap in 24-hour then 256-hour mode, fast then slow core
		deepSleep = 1;
		for (i = 0; i < 2; i++) begin
			p = {6'h0, ~i[0], 1'b0};
			wr(OFF_SETUP, p);
			repeat (4400) @(negedge clk);
			rd(OFF_SETUP, v);
			chk("setup", v, p);
			kwr(KEY_TIME, OFF_FRAC, 8'h00);
			kwr(KEY_TIME, OFF_HOUR, i ? WRAP_HOUR256 : WRAP_HOUR24);
			kwr(KEY_TIME, OFF_MIN, WRAP_SIXTY);
			kwr(KEY_TIME, OFF_SEC, WRAP_SIXTY);
			kwr(KEY_TIME, OFF_FRAC, WRAP_FRAC);
			wr(OFF_KEY, KEY_RESET);
			for (n = 0; n < 5000 && wakeReq !== 1'b1; n++) @(negedge clk);
			hang(n);
			rd(OFF_HOUR, v);
			chk("hour wrap", v, 8'h00);
			rd(OFF_SEC, v);
			chk("sec wrap", v, 8'h00);
			rd(OFF_FRAC, v);
			chk("frac wrap", v, 8'h00);
			rd(OFF_SETUP, v);
			chk("day flag", v, p | 8'h08);
			chk("irq masked", {7'h0, rtcIrqReq}, 8'h00);
			repeat (300) @(negedge clk);
			chk("wake held", {7'h0, wakeReq}, 8'h01);
			ackDelay = i ? 8'd20 : 8'd0;
			rtcIrqEnable = 1;
			for (n = 0; n < 5000 && wakeReq !== 1'b0; n++) @(negedge clk);
			hang(n);
			chk("irq served", {7'h0, rtcIrqReq}, 8'h00);
			rtcIrqEnable = 0;
			rd(OFF_SETUP, v);
			chk("flag kept", v, p | 8'h08);
		end
		// Interval alarm after one second, target of one
		wr(OFF_ALARM, 8'h01);
		wr(OFF_SETUP, 8'h01);
		repeat (4400) @(negedge clk);
		rd(OFF_ALARM, v);
		chk("alarm target", v, 8'h01);
		rd(OFF_SETUP, v);
		chk("ivl setup", v, 8'h01);
		kwr(KEY_TIME, OFF_FRAC, WRAP_FRAC);
		for (n = 0; n < 5000 && wakeReq !== 1'b1; n++) @(negedge clk);
		hang(n);
		rd(OFF_SETUP, v);
		chk("alarm flag", v, 8'h05);
		rtcIrqEnable = 1;
		for (n = 0; n < 5000 && wakeReq !== 1'b0; n++) @(negedge clk);
		hang(n);
		chk("alarm served", {7'h0, rtcIrqReq}, 8'h00);
		rtcIrqEnable = 0;
		wr(OFF_SETUP, 8'h00);
		repeat (4400) @(negedge clk);
		rd(OFF_SETUP, v);
		chk("flag clear", v, 8'h00);
		finish_test();
	end
endmodule
